// file: core/pct_map.vh
// Purpose: Offsets, field positions, reset values and timing counts of the control slice.
// Assumes: 10 MHz core clock; register images are 24 bits, bits 3..0 are the frame checksum.
// Notes:   Definitions only.
`ifndef PCT_MAP_VH
`define PCT_MAP_VH

// Register addresses.
`define PCT_ADDR_FAULT      6'h08
`define PCT_ADDR_TIMER      6'h09
`define PCT_ADDR_BUCK1      6'h0A
`define PCT_ADDR_LT_COUNT   6'h30

// Reset values of the register images.
`define PCT_RST_FAULT       24'h000020
`define PCT_RST_TIMER       24'h000000
`define PCT_RST_BUCK1       24'h000000

// Writable bits, and timer bits that freeze while counting.
`define PCT_WMASK_FAULT     24'h0FFEE0
`define PCT_WMASK_TIMER     24'h77FFF0
`define PCT_WMASK_BUCK1     24'h0FFFF0
`define PCT_LOCK_TIMER      24'h03FFC0

// Fault mask and transceiver register fields.
`define PCT_F_OC_MSB        19
`define PCT_F_OC_LSB        17
`define PCT_F_UV_MSB        16
`define PCT_F_UV_LSB        14
`define PCT_F_TW_MASK       13
`define PCT_F_OL_MASK       12
`define PCT_F_PHY_MASK      11
`define PCT_F_GW_MASK       10
`define PCT_F_TRX_ACT       9
`define PCT_F_TRX_LOOP      7
`define PCT_F_TRX_LISTEN    6
`define PCT_F_BUS_WAKE      5
`define PCT_F_GO_INIT       4

// Long timer and boost register fields.
`define PCT_T_READ_LOCK     22
`define PCT_T_FS_RELEASE    21
`define PCT_T_BOOST_STOP    20
`define PCT_T_BOOST_MASK    18
`define PCT_T_THR_MSB       17
`define PCT_T_THR_LSB       13
`define PCT_T_POS_MSB       12
`define PCT_T_POS_LSB       8
`define PCT_T_FAST          7
`define PCT_T_WAKE_MODE     6
`define PCT_T_ENABLE        5
`define PCT_T_CNT_ENABLE    4

// First regulator configuration fields.
`define PCT_B_FREQ          19
`define PCT_B_VSEL_MSB      18
`define PCT_B_VSEL_LSB      17
`define PCT_B_ON_MSB        16
`define PCT_B_ON_LSB        14
`define PCT_B_OFF_MSB       13
`define PCT_B_OFF_LSB       11

// Status byte bit positions.
`define PCT_S_GLOBAL_ERR    7
`define PCT_S_PHY_ERR       4
`define PCT_S_OPEN_LOAD     3
`define PCT_S_GLOBAL_WARN   1

// Serial frame layout and checksum.
`define PCT_CMD_WR_BIT      31
`define PCT_FRAME_BITS      6'd32
`define PCT_CRC_POLY        4'h3
`define PCT_CRC_INIT        4'hF

// Timing.
`define PCT_CLK_HZ          10000000
`define PCT_T_FAST_MS       10
`define PCT_T_SLOW_S        1
`define PCT_CYC_FAST        ((`PCT_CLK_HZ / 1000) * `PCT_T_FAST_MS)
`define PCT_CYC_SLOW        (`PCT_CLK_HZ * `PCT_T_SLOW_S)
`define PCT_BOOST_CYC       16'd1000

`endif

// file: core/pct_spi_frame.v
// Purpose: Oversampled serial slave that takes 32-bit frames and answers with status and data.
// Assumes: Mode 0 framing; the link clock is far slower than core_clk.
// Notes:   The answer in a frame carries the data of the address of the previous good frame.
`timescale 1ns/10ps
`include "pct_map.vh"
module pct_spi_frame (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rst_n,
  // Link pins.
  input  wire        spi_cs_n,
  input  wire        spi_sck,
  input  wire        spi_mosi,
  output reg         spi_miso_r,
  // Register side.
  input  wire [7:0]  status_byte,
  input  wire [23:0] rd_data,
  output reg  [5:0]  addr_r,
  output reg  [23:0] wdata_r,
  output reg         wr_stb_r,
  output reg         frame_err_r
);
  reg  [2:0]  cs_s_r;
  reg  [2:0]  sck_s_r;
  reg  [1:0]  mosi_s_r;
  reg  [31:0] sh_in_r;
  reg  [31:0] sh_out_r;
  reg  [5:0]  bits_r;
  wire        cs_fall;
  wire        cs_rise;
  wire        sck_rise;
  wire        sck_fall;
  wire [27:0] resp;
  wire [31:0] resp_word;
  wire        crc_ok;

  // Checksum over 28 bits, most significant first.
  function [3:0] pct_crc4;
    input [27:0] d;
    integer      i;
    reg   [3:0]  c;
    reg          fb;
    begin
      c = `PCT_CRC_INIT;
      for (i = 27; i >= 0; i = i - 1) begin
        fb = c[3] ^ d[i];
        c  = {c[2:0], 1'b0} ^ (fb ? `PCT_CRC_POLY : 4'h0);
      end
      pct_crc4 = c;
    end
  endfunction

  assign cs_fall   = cs_s_r[2] & ~cs_s_r[1];
  assign cs_rise   = ~cs_s_r[2] & cs_s_r[1];
  assign sck_rise  = ~cs_s_r[1] & sck_s_r[1] & ~sck_s_r[2];
  assign sck_fall  = ~cs_s_r[1] & ~sck_s_r[1] & sck_s_r[2];
  assign resp      = {status_byte, rd_data[23:4]};
  assign resp_word = {resp, pct_crc4(resp)}; // RULE_25
  assign crc_ok    = (pct_crc4(sh_in_r[31:4]) == sh_in_r[3:0]); // RULE_25

  always @(posedge core_clk) begin
    if (!rst_n) begin
      cs_s_r      <= 3'h7;
      sck_s_r     <= 3'h0;
      mosi_s_r    <= 2'h0;
      sh_in_r     <= 32'h00000000;
      sh_out_r    <= 32'h00000000;
      bits_r      <= 6'h00;
      spi_miso_r  <= 1'b0;
      addr_r      <= 6'h00;
      wdata_r     <= 24'h000000;
      wr_stb_r    <= 1'b0;
      frame_err_r <= 1'b0;
    end else begin
      cs_s_r      <= {cs_s_r[1:0], spi_cs_n};
      sck_s_r     <= {sck_s_r[1:0], spi_sck};
      mosi_s_r    <= {mosi_s_r[0], spi_mosi};
      wr_stb_r    <= 1'b0;
      frame_err_r <= 1'b0;
      if (cs_fall) begin
        bits_r     <= 6'h00;
        sh_out_r   <= resp_word;
        spi_miso_r <= resp_word[31];
      end else if (cs_rise) begin
        spi_miso_r <= 1'b0;
        if (bits_r == `PCT_FRAME_BITS && crc_ok) begin
          addr_r   <= sh_in_r[29:24];
          wdata_r  <= sh_in_r[23:0];
          wr_stb_r <= sh_in_r[`PCT_CMD_WR_BIT];
        end else begin
          frame_err_r <= 1'b1;
        end
      end else begin
        if (sck_rise) begin
          sh_in_r <= {sh_in_r[30:0], mosi_s_r[1]};
          if (bits_r <= `PCT_FRAME_BITS) begin
            bits_r <= bits_r + 6'h01;
          end
        end
        if (sck_fall) begin
          sh_out_r   <= {sh_out_r[30:0], 1'b0};
          spi_miso_r <= sh_out_r[30];
        end
      end
    end
  end
endmodule // pct_spi_frame

// file: core/pct_long_timer.v
// Purpose: Long-duration wake-up counter with selectable tick and programmable threshold.
// Assumes: Controls come from registers on core_clk.
// Notes:   Threshold is the five-bit value shifted left by the five-bit position.
`timescale 1ns/10ps
`include "pct_map.vh"
module pct_long_timer #(
  parameter [31:0] TICK_FAST_CYC = `PCT_CYC_FAST,
  parameter [31:0] TICK_SLOW_CYC = `PCT_CYC_SLOW
) (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rst_n,
  // Controls.
  input  wire        enable,
  input  wire        count_enable,
  input  wire        fast,
  input  wire        wake_mode,
  input  wire        read_lock,
  input  wire [4:0]  thr_value,
  input  wire [4:0]  msb_pos,
  // Results.
  output reg  [31:0] count_vis_r,
  output reg         wake_r
);
  reg  [31:0] presc_r;
  reg  [31:0] count_r;
  reg         cen_d_r;
  wire [31:0] tick_len;
  wire [31:0] limit;
  wire        tick;

  assign tick_len = fast ? TICK_FAST_CYC : TICK_SLOW_CYC; // RULE_17
  assign limit    = wake_mode ? ({27'h0000000, thr_value} << msb_pos) : 32'hFFFFFFFF; // RULE_16 RULE_18
  assign tick     = (presc_r == tick_len - 32'h00000001);

  always @(posedge core_clk) begin
    if (!rst_n || !enable) begin // RULE_19
      presc_r     <= 32'h00000000;
      count_r     <= 32'h00000000;
      cen_d_r     <= 1'b0;
      count_vis_r <= 32'h00000000;
      wake_r      <= 1'b0;
    end else begin
      cen_d_r <= count_enable;
      wake_r  <= 1'b0;
      if (!read_lock) begin
        count_vis_r <= count_r; // RULE_12
      end
      if (count_enable && !cen_d_r) begin
        presc_r <= 32'h00000000; // RULE_20
        count_r <= 32'h00000000;
      end else if (count_enable && count_r != limit) begin // RULE_20
        presc_r <= tick ? 32'h00000000 : presc_r + 32'h00000001;
        if (tick) begin
          count_r <= count_r + 32'h00000001;
          wake_r  <= wake_mode && (count_r + 32'h00000001 == limit); // RULE_18
        end
      end
    end
  end
endmodule // pct_long_timer

// file: core/pct_ctrl_regs.v
// Purpose: Control register slice: fault masks, status byte, transceiver, timers, regulator one.
// Assumes: All status and state inputs are asynchronous pins and are synchronised here.
// Notes:   Registers are reached only through serial frames with a 4-bit checksum.
//
// Function
// RULE_01 - Overcurrent mask 1 keeps regulator running
// RULE_02 - Undervoltage mask 1 keeps regulator running
// RULE_03 - Thermal warning mask removes it from warning
// RULE_04 - Open-load mask keeps bit 3, drops bit 7
// RULE_05 - Phy error mask keeps bit 4 only
// RULE_06 - Global warning mask keeps bit 1 only
// RULE_07 - Activate bit selects active, clears on exit
// RULE_08 - Loop bit routes transmit data to receive
// RULE_09 - Listen-only applies only with activate set
// RULE_10 - Bus wake-up enable resets to one
// RULE_11 - Init trigger works in programming state, reads zero
// RULE_12 - Read lock freezes visible timer value
// RULE_13 - Failsafe release written only in recovery one
// RULE_14 - Boost stop bit stops and resets timer
// RULE_15 - Boost end mask suppresses expiry interrupt
// RULE_16 - Threshold and position locked while counting
// RULE_17 - Fast bit ticks 10 ms, else 1 s
// RULE_18 - Wake mode stops at threshold with wake-up
// RULE_19 - Timer enable zero disables and resets
// RULE_20 - Count enable starts, holds, restarts from zero
// RULE_21 - Regulator config writable only in emulation
// RULE_22 - Frequency and voltage select decoded
// RULE_23 - Turn-on step, zero means never on
// RULE_24 - Turn-off step, codes 11X give seven
// RULE_25 - Low four frame bits carry checksum
`timescale 1ns/10ps
`include "pct_map.vh"
module pct_ctrl_regs #(
  parameter [31:0] TICK_FAST_CYC = `PCT_CYC_FAST,
  parameter [31:0] TICK_SLOW_CYC = `PCT_CYC_SLOW
) (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        rst_n,
  // Serial link.
  input  wire        spi_cs_n,
  input  wire        spi_sck,
  input  wire        spi_mosi,
  output wire        spi_miso_r,
  output wire        frame_err_r,
  // Regulator faults and shutdown.
  input  wire [2:0]  reg_overcurrent,
  input  wire [2:0]  reg_undervoltage,
  output reg  [2:0]  reg_shutdown_r,
  // Status sources.
  input  wire        thermal_warn,
  input  wire        other_warn,
  input  wire        open_load,
  input  wire        phy_error,
  output reg  [7:0]  global_status_byte_r,
  // Transceiver.
  input  wire        trx_txd,
  input  wire        trx_bus_rxd,
  input  wire        trx_left_active,
  input  wire        bus_activity,
  output reg         trx_active_r,
  output reg         trx_tx_enable_r,
  output reg         trx_rxd_r,
  output reg         bus_wakeup_r,
  // Device state.
  input  wire        nvm_programming_state,
  input  wire        nvm_emulation,
  input  wire        nvm_programmed,
  input  wire        recovery_one_state,
  input  wire        active_high_power_state,
  input  wire        failsafe_conditions_ok,
  output reg         go_init_r,
  output reg         failsafe_output_n_r,
  // Boost timer.
  input  wire        boost_active,
  output reg         boost_end_irq_r,
  // Long-duration timer.
  output wire        long_timer_wake_r,
  // First regulator configuration.
  output reg         reg1_switch_freq_r,
  output reg  [1:0]  reg1_voltage_select_r,
  output reg  [2:0]  reg1_on_step_r,
  output reg  [2:0]  reg1_off_step_r
);
  localparam NSYNC = 21;

  reg  [NSYNC-1:0] pin_s1_r;
  reg  [NSYNC-1:0] pin_s2_r;
  reg  [23:0]      fault_r;
  reg  [23:0]      fault_nxt;
  reg  [23:0]      timer_r;
  reg  [23:0]      timer_nxt;
  reg  [23:0]      buck1_r;
  reg  [23:0]      buck1_nxt;
  reg  [23:0]      rd_data;
  reg  [23:0]      timer_wm;
  reg  [15:0]      boost_cnt_r;
  reg              bus_prev_r;
  reg              recovery_one_state_prev_r;
  wire [5:0]       addr;
  wire [23:0]      wdata;
  wire             wr_stb;
  wire [31:0]      lt_count;
  wire [2:0]       oc_s;
  wire [2:0]       uv_s;
  wire             tw_s;
  wire             ow_s;
  wire             ol_s;
  wire             phy_s;
  wire             txd_s;
  wire             brxd_s;
  wire             left_s;
  wire             bact_s;
  wire             prog_s;
  wire             emu_s;
  wire             nvmp_s;
  wire             recovery_one_state_s;
  wire             ahp_s;
  wire             fsok_s;
  wire             boost_s;
  wire             gw;
  wire             fs_release;

  // Pins pass two flip-flops before use.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pin_s1_r <= {NSYNC{1'b0}};
      pin_s2_r <= {NSYNC{1'b0}};
    end else begin
      pin_s1_r <= {reg_overcurrent, reg_undervoltage, thermal_warn, other_warn, open_load,
                   phy_error, trx_txd, trx_bus_rxd, trx_left_active, bus_activity,
                   nvm_programming_state, nvm_emulation, nvm_programmed, recovery_one_state,
                   active_high_power_state, failsafe_conditions_ok, boost_active};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign {oc_s, uv_s, tw_s, ow_s, ol_s, phy_s, txd_s, brxd_s, left_s, bact_s,
          prog_s, emu_s, nvmp_s, recovery_one_state_s, ahp_s, fsok_s, boost_s} = pin_s2_r;

  pct_spi_frame u_spi (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .spi_cs_n    (spi_cs_n),
    .spi_sck     (spi_sck),
    .spi_mosi    (spi_mosi),
    .spi_miso_r  (spi_miso_r),
    .status_byte (global_status_byte_r),
    .rd_data     (rd_data),
    .addr_r      (addr),
    .wdata_r     (wdata),
    .wr_stb_r    (wr_stb),
    .frame_err_r (frame_err_r)
  );

  // Read data; checksum bits and unmapped addresses read as zero.
  always @* begin
    case (addr)
      `PCT_ADDR_FAULT:    rd_data = fault_r & 24'hFFFFE0; // RULE_11
      `PCT_ADDR_TIMER:    rd_data = timer_r;
      `PCT_ADDR_BUCK1:    rd_data = buck1_r;
      `PCT_ADDR_LT_COUNT: rd_data = {lt_count[19:0], 4'h0};
      default:            rd_data = 24'h000000;
    endcase
  end

  // Next register images.
  always @* begin
    fault_nxt = fault_r;
    timer_nxt = timer_r;
    buck1_nxt = buck1_r;
    timer_wm  = `PCT_WMASK_TIMER;
    if (timer_r[`PCT_T_CNT_ENABLE]) begin
      timer_wm = timer_wm & ~`PCT_LOCK_TIMER; // RULE_16 RULE_17 RULE_18
    end
    if (wdata[`PCT_T_FS_RELEASE] && !recovery_one_state_s) begin
      timer_wm[`PCT_T_FS_RELEASE] = 1'b0; // RULE_13
    end
    if (wr_stb && addr == `PCT_ADDR_FAULT) begin
      fault_nxt = (fault_r & ~`PCT_WMASK_FAULT) | (wdata & `PCT_WMASK_FAULT);
    end
    if (wr_stb && addr == `PCT_ADDR_TIMER) begin
      timer_nxt = (timer_r & ~timer_wm) | (wdata & timer_wm);
    end
    if (wr_stb && addr == `PCT_ADDR_BUCK1 && emu_s && !nvmp_s) begin
      buck1_nxt = (buck1_r & ~`PCT_WMASK_BUCK1) | (wdata & `PCT_WMASK_BUCK1); // RULE_21
    end
    if (left_s) begin
      fault_nxt[`PCT_F_TRX_ACT] = 1'b0; // RULE_07
    end
  end

  always @(posedge core_clk) begin
    if (!rst_n) begin
      fault_r <= `PCT_RST_FAULT; // RULE_10
      timer_r <= `PCT_RST_TIMER;
      buck1_r <= `PCT_RST_BUCK1;
    end else begin
      fault_r <= fault_nxt;
      timer_r <= timer_nxt;
      buck1_r <= buck1_nxt;
    end
  end

  // Fault masking and status byte.
  assign gw = (tw_s & ~fault_r[`PCT_F_TW_MASK]) | ow_s; // RULE_03

  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg_shutdown_r       <= 3'h0;
      global_status_byte_r <= 8'h00;
    end else begin
      reg_shutdown_r <= (oc_s & ~fault_r[`PCT_F_OC_MSB:`PCT_F_OC_LSB])  // RULE_01
                      | (uv_s & ~fault_r[`PCT_F_UV_MSB:`PCT_F_UV_LSB]); // RULE_02
      global_status_byte_r                     <= 8'h00;
      global_status_byte_r[`PCT_S_OPEN_LOAD]   <= ol_s;  // RULE_04
      global_status_byte_r[`PCT_S_PHY_ERR]     <= phy_s; // RULE_05
      global_status_byte_r[`PCT_S_GLOBAL_WARN] <= gw;    // RULE_06
      global_status_byte_r[`PCT_S_GLOBAL_ERR]  <= (ol_s & ~fault_r[`PCT_F_OL_MASK])   // RULE_04
                                                | (phy_s & ~fault_r[`PCT_F_PHY_MASK]) // RULE_05
                                                | (gw & ~fault_r[`PCT_F_GW_MASK]);    // RULE_06
    end
  end

  // Transceiver controls, wake-up and init trigger.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      trx_active_r    <= 1'b0;
      trx_tx_enable_r <= 1'b0;
      trx_rxd_r       <= 1'b1;
      bus_wakeup_r    <= 1'b0;
      bus_prev_r      <= 1'b0;
      go_init_r       <= 1'b0;
    end else begin
      trx_active_r    <= fault_r[`PCT_F_TRX_ACT]; // RULE_07
      trx_tx_enable_r <= fault_r[`PCT_F_TRX_ACT] & ~fault_r[`PCT_F_TRX_LISTEN]; // RULE_09
      trx_rxd_r       <= fault_r[`PCT_F_TRX_LOOP] ? txd_s : brxd_s; // RULE_08
      bus_prev_r      <= bact_s;
      bus_wakeup_r    <= bact_s & ~bus_prev_r & fault_r[`PCT_F_BUS_WAKE]; // RULE_10
      go_init_r       <= wr_stb && addr == `PCT_ADDR_FAULT && wdata[`PCT_F_GO_INIT]
                         && prog_s; // RULE_11
    end
  end

  // Failsafe output, active low.
  assign fs_release = fsok_s & ((timer_r[`PCT_T_FS_RELEASE] & recovery_one_state_s)        // RULE_13
                              | (recovery_one_state_prev_r & ~recovery_one_state_s & ahp_s));

  always @(posedge core_clk) begin
    if (!rst_n) begin
      failsafe_output_n_r <= 1'b0;
      recovery_one_state_prev_r         <= 1'b0;
    end else begin
      recovery_one_state_prev_r <= recovery_one_state_s;
      if (!fsok_s) begin
        failsafe_output_n_r <= 1'b0;
      end else if (fs_release) begin
        failsafe_output_n_r <= 1'b1; // RULE_13
      end
    end
  end

  // Boost timer.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      boost_cnt_r     <= 16'h0000;
      boost_end_irq_r <= 1'b0;
    end else begin
      boost_end_irq_r <= 1'b0;
      if (timer_r[`PCT_T_BOOST_STOP] || !boost_s) begin
        boost_cnt_r <= 16'h0000; // RULE_14
      end else if (boost_cnt_r != `PCT_BOOST_CYC) begin
        boost_cnt_r     <= boost_cnt_r + 16'h0001;
        boost_end_irq_r <= (boost_cnt_r == `PCT_BOOST_CYC - 16'h0001)
                           & ~timer_r[`PCT_T_BOOST_MASK]; // RULE_15
      end
    end
  end

  pct_long_timer #(
    .TICK_FAST_CYC (TICK_FAST_CYC),
    .TICK_SLOW_CYC (TICK_SLOW_CYC)
  ) u_ltimer (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .enable       (timer_r[`PCT_T_ENABLE]),
    .count_enable (timer_r[`PCT_T_CNT_ENABLE]),
    .fast         (timer_r[`PCT_T_FAST]),
    .wake_mode    (timer_r[`PCT_T_WAKE_MODE]),
    .read_lock    (timer_r[`PCT_T_READ_LOCK]),
    .thr_value    (timer_r[`PCT_T_THR_MSB:`PCT_T_THR_LSB]),
    .msb_pos      (timer_r[`PCT_T_POS_MSB:`PCT_T_POS_LSB]),
    .count_vis_r  (lt_count),
    .wake_r       (long_timer_wake_r)
  );

  // First regulator configuration decode.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      reg1_switch_freq_r    <= 1'b0;
      reg1_voltage_select_r <= 2'h0;
      reg1_on_step_r        <= 3'h0;
      reg1_off_step_r       <= 3'h1;
    end else begin
      reg1_switch_freq_r    <= buck1_r[`PCT_B_FREQ]; // RULE_22
      reg1_voltage_select_r <= buck1_r[`PCT_B_VSEL_MSB] ? 2'h2
                               : {1'b0, buck1_r[`PCT_B_VSEL_LSB]}; // RULE_22
      reg1_on_step_r        <= buck1_r[`PCT_B_ON_MSB:`PCT_B_ON_LSB]; // RULE_23
      reg1_off_step_r       <= buck1_r[`PCT_B_OFF_MSB] && buck1_r[`PCT_B_OFF_MSB-1] ? 3'h7
                               : buck1_r[`PCT_B_OFF_MSB:`PCT_B_OFF_LSB] + 3'h1; // RULE_24
    end
  end
endmodule // pct_ctrl_regs

// file: tb/pct_ctrl_regs_properties.sv
// Purpose: Port assertions of the control slice.
// Assumes: Inputs are synchronised in two stages.
// Notes:   Bound by module name.
`timescale 1ns/10ps
module pct_regs_chk (
  // Clock and reset.
  input logic       core_clk,
  input logic       rst_n,
  // Watched ports.
  input logic       frame_err_r,
  input logic       open_load,
  input logic       phy_error,
  input logic       other_warn,
  input logic [7:0] global_status_byte_r,
  input logic       trx_left_active,
  input logic       trx_active_r,
  input logic       trx_tx_enable_r,
  input logic       failsafe_conditions_ok,
  input logic       failsafe_output_n_r,
  input logic       nvm_programming_state,
  input logic       go_init_r,
  input logic       boost_active,
  input logic       boost_end_irq_r,
  input logic       long_timer_wake_r
);
  // Counts cycles of uninterrupted boost activity.
  logic [10:0] act_cnt_r;
  always @(posedge core_clk) begin
    if (!rst_n || !boost_active) act_cnt_r <= 11'h000;
    else if (act_cnt_r != 11'h7FF) act_cnt_r <= act_cnt_r + 11'h001;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_boost_full_count: assert property (boost_end_irq_r |-> act_cnt_r >= 11'h3E8)
    else $error("early boost expiry");
  chk_frame_err_pulse: assert property (frame_err_r |=> !frame_err_r)
    else $error("long frame error");
  chk_wake_pulse: assert property (long_timer_wake_r |=> !long_timer_wake_r)
    else $error("long wake pulse");
  chk_tx_needs_act: assert property (trx_tx_enable_r |-> trx_active_r || $past(trx_active_r))
    else $error("tx while inactive");
  chk_act_hw_clear: assert property (trx_left_active [*4] |=> !trx_active_r)
    else $error("activate bit not cleared");
  chk_phy_status: assert property (phy_error [*4] |=> global_status_byte_r[4])
    else $error("phy status bit missing");
  chk_open_load_status: assert property (open_load [*4] |=> global_status_byte_r[3])
    else $error("open load status bit missing");
  chk_warn_status: assert property (other_warn [*4] |=> global_status_byte_r[1])
    else $error("warning status bit missing");
  chk_init_in_prog: assert property (go_init_r |-> $past(nvm_programming_state, 2) ||
    $past(nvm_programming_state, 3) || $past(nvm_programming_state, 4))
    else $error("init outside programming");
  chk_fs_forced: assert property (!failsafe_conditions_ok [*4] |=> !failsafe_output_n_r)
    else $error("failsafe not forced");
endmodule // pct_regs_chk
bind pct_ctrl_regs pct_regs_chk u_chk (.*);

// file: tb/pct_host_model.sv
// Purpose: Host end of the link; 32-bit checksummed frames.
// Assumes: Link clock period 800 ns, off phase from the core clock.
// Notes:   Data line is inverted between frames.
`timescale 1ns/10ps
module pct_host_model (
  // Link pins.
  output logic      spi_cs_n,
  output logic      spi_sck,
  output logic      spi_mosi,
  input  wire logic spi_miso_r
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b1;
  end
  function automatic [3:0] crc4(input [27:0] d);
    integer i;
    reg [3:0] c;
    c = 4'hF;
    for (i = 27; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'h3 : 4'h0);
    return c;
  endfunction
  // Sends one frame; bad spoils the checksum.
  task automatic xfer(input [27:0] w, input bad, output [31:0] ans);
    integer i;
    reg [31:0] f;
    f = {w, crc4(w) ^ {4{bad}}};
    #37 spi_cs_n = 1'b0;
    for (i = 31; i >= 0; i--) begin
      spi_mosi = f[i];
      #400 spi_sck = 1'b1;
      ans[i] = spi_miso_r;
      #400 spi_sck = 1'b0;
    end
    #400 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #1000;
  endtask
endmodule // pct_host_model

// file: tb/tb_top.sv
// Purpose: Bench for the control slice.
// Assumes: Ticks of 20 and 50 cycles.
// Notes:   Each scenario is one task.
`timescale 1ns/10ps
`include "pct_map.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb_top;
  logic core_clk = 1'b0, rst_n = 1'b0, thermal_warn = 1'b0, other_warn = 1'b0;
  logic open_load = 1'b0, phy_error = 1'b0, trx_txd = 1'b1, trx_bus_rxd = 1'b1;
  logic trx_left_active = 1'b0, bus_activity = 1'b0, nvm_programming_state = 1'b0;
  logic nvm_emulation = 1'b0, nvm_programmed = 1'b0, recovery_one_state = 1'b0;
  logic active_high_power_state = 1'b0, failsafe_conditions_ok = 1'b0, boost_active = 1'b0;
  logic [2:0] reg_overcurrent = 3'h0, reg_undervoltage = 3'h0;
  wire spi_cs_n, spi_sck, spi_mosi, spi_miso_r, frame_err_r, trx_active_r, trx_tx_enable_r;
  wire trx_rxd_r, bus_wakeup_r, go_init_r, failsafe_output_n_r, boost_end_irq_r;
  wire long_timer_wake_r, reg1_switch_freq_r;
  wire [2:0] reg_shutdown_r, reg1_on_step_r, reg1_off_step_r;
  wire [1:0] reg1_voltage_select_r;
  wire [7:0] global_status_byte_r;
  int errors = 0, samples_checked = 0, n_err = 0, n_init = 0, n_wake = 0, n_irq = 0, k;
  pct_ctrl_regs #(.TICK_FAST_CYC(20), .TICK_SLOW_CYC(50)) uut (.*);
  pct_host_model host (.spi_cs_n, .spi_sck, .spi_mosi, .spi_miso_r);
  initial forever #50 core_clk = ~core_clk;
  // Counts pulses.
  always @(posedge core_clk) begin
    n_err <= n_err + (frame_err_r === 1'b1);
    n_init <= n_init + (go_init_r === 1'b1);
    n_wake <= n_wake + (long_timer_wake_r === 1'b1);
    n_irq <= n_irq + (boost_end_irq_r === 1'b1);
  end
  task automatic go(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input [5:0] a, input [23:0] d, input bad = 1'b0);
    logic [31:0] ans;
    host.xfer({2'b10, a, d[23:4]}, bad, ans);
    go(8);
  endtask
  task automatic rc(input [5:0] a, input [23:0] e);
    logic [31:0] ans;
    host.xfer({2'b00, a, 20'h00000}, 1'b0, ans);
    host.xfer({2'b00, a, 20'h00000}, 1'b0, ans);
    `CHK("answer checksum", host.crc4(ans[31:4]), ans[3:0])
    `CHK("readback", e, {ans[23:4], 4'h0})
  endtask
  task automatic s_reset;
    rc(`PCT_ADDR_FAULT, 24'h000020);
    rc(`PCT_ADDR_TIMER, 24'h000000);
    `CHK("off step", 3'h1, reg1_off_step_r)
  endtask
  task automatic s_fault;
    wr(`PCT_ADDR_FAULT, 24'h025C20);
    @(posedge core_clk) reg_overcurrent <= 3'h7;
    go(6);
    `CHK("oc shutdown", 3'h6, reg_shutdown_r)
    reg_overcurrent <= 3'h0;
    reg_undervoltage <= 3'h7;
    {open_load, phy_error, other_warn} <= 3'h7;
    go(6);
    `CHK("uv shutdown", 3'h6, reg_shutdown_r)
    `CHK("masked status", 8'h1A, global_status_byte_r)
    wr(`PCT_ADDR_FAULT, 24'h000020);
    `CHK("open status", 8'h9A, global_status_byte_r)
    {open_load, phy_error, other_warn} <= 3'h0;
    reg_undervoltage <= 3'h0;
  endtask
  task automatic s_trx;
    @(posedge core_clk) trx_txd <= 1'b0;
    wr(`PCT_ADDR_FAULT, 24'h0002A0);
    `CHK("active", 1'b1, trx_active_r)
    `CHK("tx enable", 1'b1, trx_tx_enable_r)
    `CHK("loop rxd", 1'b0, trx_rxd_r)
    wr(`PCT_ADDR_FAULT, 24'h0002E0);
    `CHK("listen tx", 1'b0, trx_tx_enable_r)
    trx_left_active <= 1'b1;
    go(6);
    `CHK("left active", 1'b0, trx_active_r)
    trx_left_active <= 1'b0;
    rc(`PCT_ADDR_FAULT, 24'h0000E0);
  endtask
  task automatic s_init_bad;
    k = n_init;
    wr(`PCT_ADDR_FAULT, 24'h000030);
    @(posedge core_clk) nvm_programming_state <= 1'b1;
    wr(`PCT_ADDR_FAULT, 24'h000030);
    `CHK("init pulses", k + 1, n_init)
    k = n_err;
    wr(`PCT_ADDR_FAULT, 24'h000220, 1'b1);
    `CHK("frame errors", k + 1, n_err)
    rc(`PCT_ADDR_FAULT, 24'h000020);
  endtask
  task automatic s_timer;
    k = n_wake;
    wr(`PCT_ADDR_TIMER, 24'h0060E0);
    wr(`PCT_ADDR_TIMER, 24'h0060F0);
    go(100);
    `CHK("wake pulses", k + 1, n_wake)
    wr(`PCT_ADDR_TIMER, 24'h00E0B0);
    rc(`PCT_ADDR_TIMER, 24'h0060F0);
    rc(`PCT_ADDR_LT_COUNT, 24'h000030);
    wr(`PCT_ADDR_TIMER, 24'h000000);
    rc(`PCT_ADDR_LT_COUNT, 24'h000000);
  endtask
  task automatic s_buck;
    @(posedge core_clk) nvm_emulation <= 1'b1;
    wr(`PCT_ADDR_BUCK1, 24'h0AF000);
    `CHK("config", 9'h15F, {reg1_switch_freq_r, reg1_voltage_select_r, reg1_on_step_r,
      reg1_off_step_r})
    nvm_programmed <= 1'b1;
    wr(`PCT_ADDR_BUCK1, 24'h000000);
    rc(`PCT_ADDR_BUCK1, 24'h0AF000);
  endtask
  task automatic s_boost(input [23:0] d, input int e);
    k = n_irq;
    wr(`PCT_ADDR_TIMER, d);
    @(posedge core_clk) boost_active <= 1'b1;
    go(1010);
    boost_active <= 1'b0;
    go(4);
    `CHK("boost irqs", k + e, n_irq)
  endtask
  task automatic s_fs;
    @(posedge core_clk) failsafe_conditions_ok <= 1'b1;
    wr(`PCT_ADDR_TIMER, 24'h200000);
    `CHK("fs outside recovery_one_state", 1'b0, failsafe_output_n_r)
    recovery_one_state <= 1'b1;
    go(4);
    wr(`PCT_ADDR_TIMER, 24'h200000);
    `CHK("fs released", 1'b1, failsafe_output_n_r)
    failsafe_conditions_ok <= 1'b0;
    go(6);
    `CHK("fs forced", 1'b0, failsafe_output_n_r)
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #5000000;
    errors++;
    complete_run;
  end
  initial begin
    go(5);
    rst_n <= 1'b1;
    go(3);
    s_reset;
    s_fault;
    s_trx;
    s_init_bad;
    s_timer;
    s_buck;
    s_boost(24'h000000, 1);
    s_boost(24'h040000, 0);
    s_boost(24'h100000, 0);
    s_fs;
    complete_run;
  end
endmodule // tb_top
